// ===== hw/video_regs_pkg.sv
package video_regs_pkg;
    // Register indices; the APB byte address is four times the index
    localparam logic [7:0]  IDX_GEN_VCTRL    = 8'h12;
    localparam logic [7:0]  IDX_STD_STATUS   = 8'h13;
    localparam logic [7:0]  IDX_NOISE        = 8'h14;
    localparam logic [7:0]  IDX_FIELD_CNT    = 8'h15;
    localparam logic [7:0]  IDX_BURST_AMPL   = 8'h31;
    localparam logic [7:0]  IDX_SCALER_MODE  = 8'h40;
    localparam logic [7:0]  IDX_LUMA_OFFSET  = 8'h41;
    localparam logic [7:0]  IDX_SYNC_AMPL    = 8'h74;
    localparam logic [7:0]  IDX_AUTO_LOCK    = 8'hb5;
    localparam logic [7:0]  IDX_LINES_FIELD  = 8'hcb;
    localparam logic [7:0]  IDX_FW_VERSION   = 8'hf0;
    localparam logic [7:0]  IDX_HW_VERSION   = 8'hf1;
    localparam logic [7:0]  IDX_XLOCK_CTRL   = 8'hf7;
    // Reset values
    localparam logic [11:0] RST_GEN_VCTRL    = 12'h000;
    localparam logic [11:0] RST_SCALER_MODE  = 12'h000;
    localparam logic [6:0]  RST_LUMA_OFFSET  = 7'h39;
    localparam logic [11:0] RST_AUTO_LOCK    = 12'h190;
    localparam logic [1:0]  RST_KILL_DIS     = 2'h0;
    // Lock command values and lock readback
    localparam logic [11:0] XLOCK_CMD_ON     = 12'h064;
    localparam logic [11:0] XLOCK_CMD_OFF    = 12'h000;
    localparam logic [11:0] XLOCK_RD_LOCKED  = 12'h800;
    // Lines per field
    localparam logic [11:0] LPF_50HZ         = 12'h138;
    localparam logic [11:0] LPF_60HZ         = 12'h106;
    // Field positions
    localparam int          GV_VFORCE_BIT    = 3;
    localparam int          GV_DFLY_BIT      = 9;
    localparam int          SM_UPDATE_BIT    = 11;
    localparam logic [11:0] SM_WRITE_MASK    = 12'h0db;
    localparam logic [11:0] ST_KILL_DIS_MASK = 12'h050;
    // Version contents (values arbitrary)
    localparam logic [7:0]  FW_INT_REV       = 8'h01;
    localparam logic [3:0]  FW_RELEASE       = 4'h1;
    localparam logic [5:0]  HW_INT_REV       = 6'h01;
    localparam logic [5:0]  HW_ID_CODE       = 6'h2a;

    // Status and measurements from the video core
    typedef struct packed {
        logic        vlock;         // Vertically locked
        logic        hlock;         // Horizontally locked
        logic        no_signal;     // No input signal
        logic        ampl_kill;     // Amplitude killer active
        logic        ident_kill;    // Ident killer active
        logic        interlace;     // Interlace detected
        logic        no_vsync;      // No vertical sync
        logic        spur_vsync;    // Spurious vertical sync
        logic        std_50hz;      // PAL/SECAM line count
        logic [11:0] noise;         // Noise level
        logic [11:0] sync_ampl;     // Sync amplitude
        logic [11:0] burst_ampl;    // Burst amplitude
    } core_status_t;

    // Active scaler setting
    typedef struct packed {
        logic [1:0]  scaling_mode_field;        // 0 panorama, 2 waterglass
        logic        colour_arrangement_select; // 0 4:2:2, 1 4:1:1
        logic        scaler_bypass_bit;         // Bypass scaler
        logic        luma_coding_select;        // 0 ITU-R, 1 composite
        logic        chroma_coding_select;      // 0 offset binary, 1 signed
        logic [6:0]  luma_offset_level;         // Luma offset
    } scaler_cfg_t;
endpackage : video_regs_pkg

// ===== hw/video_lock_status_scaler_regs.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module video_lock_status_scaler_regs
    import video_regs_pkg::*;
(
    input  wire logic         CLOCK,          // 200 MHz clock
    input  wire logic         RST_N,          // Async reset, active low
    input  wire logic         PSEL,           // APB select
    input  wire logic         PENABLE,        // APB access phase
    input  wire logic         PWRITE,         // APB write
    input  wire logic [11:0]  PADDR,          // APB byte address
    input  wire logic [31:0]  PWDATA,         // APB write data
    output logic              PREADY,         // APB ready
    output logic              PSLVERR,        // APB error, unmapped
    output logic [31:0]       PRDATA,         // APB read data
    input  wire core_status_t CORE_STATUS,    // Video core status
    input  wire logic         FIELD_PULSE,    // One pulse per field
    input  wire logic         XTAL_LOCKED,    // Oscillator reports lock
    output logic              XTAL_LOCK_EN,   // Run line locking
    output logic              VERT_FORCE,     // Vertical standard force
    output logic              FLYWHEEL_DIS,   // Interlace flywheel off
    output logic              VERT_FREE_RUN,  // Vertical free-run
    output logic              AMPL_KILL_DIS,  // Amplitude killer off
    output logic              IDENT_KILL_DIS, // Ident killer off
    output scaler_cfg_t       SCALER_CFG,     // Active scaler setting
    output logic              SCALER_UPDATE   // Pulse on scaler load
);

    // Bus decode
    logic        addr_ok;        // Word aligned, in range
    logic [7:0]  idx;            // Register index
    logic        hit;            // Index is mapped
    logic        wr_en;          // Write in access phase
    logic        rd_setup;       // Read setup phase
    logic [11:0] rd_val;         // Selected read value
    logic [11:0] wdata;          // Low write bits

    // Software registers
    logic        lock_cmd_r;     // Software lock command
    logic [11:0] auto_th_r;      // Autolock threshold
    logic [11:0] gen_vctrl_r;    // General vertical control
    logic [1:0]  kill_dis_r;     // Killer disable bits
    logic [11:0] scaler_mode_r;  // Stored scaler mode
    logic        upd_done_r;     // Update done flag
    logic [6:0]  luma_off_r;     // Staged luma offset
    scaler_cfg_t cfg_r;          // Active scaler setting
    logic        upd_pulse_r;    // Update strobe

    // Device state
    logic [11:0] field_cnt_r;    // Field counter
    logic [31:0] prdata_r;       // Read data register
    logic        pslverr_r;      // Error for current access
    logic        auto_on;        // Autolock enabled
    logic [11:0] status_word;    // Assembled status
    logic [11:0] lpf_word;       // Lines per field

    // Address split; index is the byte address over four
    // Misaligned or out-of-range addresses never reach a register
    assign addr_ok  = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);
    assign idx      = PADDR[9:2];
    assign wdata    = PWDATA[11:0];
    assign wr_en    = PSEL && PENABLE && PWRITE && addr_ok;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;

    // Mapped index check
    // Unmapped places answer with an error and read as zero
    always_comb begin
        if (!addr_ok) begin
            hit = 1'b0;
        end else if (idx == IDX_GEN_VCTRL || idx == IDX_STD_STATUS) begin
            hit = 1'b1;
        end else if (idx == IDX_NOISE || idx == IDX_FIELD_CNT) begin
            hit = 1'b1;
        end else if (idx == IDX_BURST_AMPL || idx == IDX_SCALER_MODE) begin
            hit = 1'b1;
        end else if (idx == IDX_LUMA_OFFSET || idx == IDX_SYNC_AMPL) begin
            hit = 1'b1;
        end else if (idx == IDX_AUTO_LOCK || idx == IDX_LINES_FIELD) begin
            hit = 1'b1;
        end else if (idx == IDX_FW_VERSION || idx == IDX_HW_VERSION) begin
            hit = 1'b1;
        end else if (idx == IDX_XLOCK_CTRL) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Status assembly from live core flags and the stored killer disable bits
    always_comb begin
        status_word     = 12'h000;
        status_word[0]  = CORE_STATUS.vlock;
        status_word[1]  = CORE_STATUS.hlock;
        status_word[2]  = CORE_STATUS.no_signal;
        status_word[3]  = CORE_STATUS.ampl_kill;
        status_word[4]  = kill_dis_r[0];
        status_word[5]  = CORE_STATUS.ident_kill;
        status_word[6]  = kill_dis_r[1];
        status_word[7]  = CORE_STATUS.interlace;
        status_word[8]  = CORE_STATUS.no_vsync;
        status_word[9]  = CORE_STATUS.spur_vsync;
    end

    // Lines per field from detected standard
    assign lpf_word = CORE_STATUS.std_50hz ? LPF_50HZ : LPF_60HZ;

    // Read mux; pure selection, no read side effects
    // Index alone picks the value; hit gates it at capture
    always_comb begin
        if (idx == IDX_GEN_VCTRL) begin
            rd_val = gen_vctrl_r;
        end else if (idx == IDX_STD_STATUS) begin
            rd_val = status_word;
        end else if (idx == IDX_NOISE) begin
            rd_val = CORE_STATUS.noise;
        end else if (idx == IDX_FIELD_CNT) begin
            rd_val = field_cnt_r;
        end else if (idx == IDX_BURST_AMPL) begin
            rd_val = CORE_STATUS.burst_ampl;
        end else if (idx == IDX_SCALER_MODE) begin
            rd_val = {upd_done_r, scaler_mode_r[10:0]};
        end else if (idx == IDX_LUMA_OFFSET) begin
            rd_val = {5'h00, luma_off_r};
        end else if (idx == IDX_SYNC_AMPL) begin
            rd_val = CORE_STATUS.sync_ampl;
        end else if (idx == IDX_AUTO_LOCK) begin
            rd_val = auto_th_r;
        end else if (idx == IDX_LINES_FIELD) begin
            rd_val = lpf_word;
        end else if (idx == IDX_FW_VERSION) begin
            rd_val = {FW_RELEASE, FW_INT_REV};
        end else if (idx == IDX_HW_VERSION) begin
            rd_val = {HW_ID_CODE, HW_INT_REV};
        end else if (idx == IDX_XLOCK_CTRL) begin
            rd_val = XTAL_LOCKED ? XLOCK_RD_LOCKED : 12'h000;
        end else begin
            rd_val = 12'h000;
        end
    end

    // Read data captured in setup phase, held through access
    // Capturing early keeps PRDATA steady for the whole access
    // Write transfers leave the read register untouched
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_r <= hit ? {20'h00000, rd_val} : 32'h0000_0000;
        end
    end

    // Error flag captured in setup phase
    // Covers writes too, so an unmapped write also reports
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pslverr_r <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            pslverr_r <= !hit;
        end
    end

    // Zero wait state slave
    // Every register answers in its first access cycle
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && pslverr_r;
    assign PRDATA  = prdata_r;

    // Line-lock command; other values leave it unchanged
    // Readback shows oscillator status, not this command
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            lock_cmd_r <= 1'b0;
        end else if (wr_en && idx == IDX_XLOCK_CTRL) begin
            if (wdata == XLOCK_CMD_ON) begin
                lock_cmd_r <= 1'b1;
            end else if (wdata == XLOCK_CMD_OFF) begin
                lock_cmd_r <= 1'b0;
            end
        end
    end

    // Autolock threshold
    // All twelve bits kept; only zero has a special meaning
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            auto_th_r <= RST_AUTO_LOCK;
        end else if (wr_en && idx == IDX_AUTO_LOCK) begin
            auto_th_r <= wdata;
        end
    end

    // Zero threshold switches autolock off
    assign auto_on = (auto_th_r != 12'h000);

    // Locking runs on command or, with autolock, on a present signal
    // Autolock waits for a signal so a dead input does not hunt
    // Registered so the oscillator sees a clean enable
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            XTAL_LOCK_EN <= 1'b0;
        end else begin
            XTAL_LOCK_EN <= lock_cmd_r || (auto_on && !CORE_STATUS.no_signal);
        end
    end

    // General vertical control; reserved bits kept as written
    // Software may read it back and rewrite reserved bits as found
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            gen_vctrl_r <= RST_GEN_VCTRL;
        end else if (wr_en && idx == IDX_GEN_VCTRL) begin
            gen_vctrl_r <= wdata;
        end
    end

    // Vertical control outputs
    // Free run decoded here so the core gets one clean level
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            VERT_FORCE    <= 1'b0;
            FLYWHEEL_DIS  <= 1'b0;
            VERT_FREE_RUN <= 1'b0;
        end else begin
            VERT_FORCE    <= gen_vctrl_r[GV_VFORCE_BIT];
            FLYWHEEL_DIS  <= gen_vctrl_r[GV_DFLY_BIT];
            VERT_FREE_RUN <= gen_vctrl_r[GV_VFORCE_BIT] && !gen_vctrl_r[GV_DFLY_BIT];
        end
    end

    // Killer disable bits, the writable part of the status register
    // Live status bits ignore writes; only these two store
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            kill_dis_r <= RST_KILL_DIS;
        end else if (wr_en && idx == IDX_STD_STATUS) begin
            kill_dis_r <= {wdata[6], wdata[4]};
        end
    end

    // Killer disable outputs
    assign AMPL_KILL_DIS  = kill_dis_r[0];
    assign IDENT_KILL_DIS = kill_dis_r[1];

    // Field counter, wraps at twelve bits
    // Software takes differences, so the wrap is harmless
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            field_cnt_r <= 12'h000;
        end else if (FIELD_PULSE) begin
            field_cnt_r <= field_cnt_r + 12'h001;
        end
    end

    // Staged luma offset, not yet applied
    // Held here until the next scaler mode write moves it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            luma_off_r <= RST_LUMA_OFFSET;
        end else if (wr_en && idx == IDX_LUMA_OFFSET) begin
            luma_off_r <= wdata[6:0];
        end
    end

    // Stored scaler mode; reserved bits forced to zero
    // Readback shows the last write, even one without update
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            scaler_mode_r <= RST_SCALER_MODE;
        end else if (wr_en && idx == IDX_SCALER_MODE) begin
            scaler_mode_r <= wdata & SM_WRITE_MASK;
        end
    end

    // Update flag: cleared by a write with bit 11 low, set next cycle
    // Accesses are two cycles apart, so set and clear never meet;
    // should they, the set is seen first and wins
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            upd_done_r <= 1'b0;
        end else if (upd_pulse_r) begin
            upd_done_r <= 1'b1;
        end else if (wr_en && idx == IDX_SCALER_MODE && !wdata[SM_UPDATE_BIT]) begin
            upd_done_r <= 1'b0;
        end
    end

    // Update strobe one cycle after an update command
    // Tells the scaler core to reload its setting
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            upd_pulse_r <= 1'b0;
        end else begin
            upd_pulse_r <= wr_en && idx == IDX_SCALER_MODE && !wdata[SM_UPDATE_BIT];
        end
    end

    // Active scaler setting; luma offset follows any scaler mode write
    // A write with bit 11 set still moves the offset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_r <= '{scaling_mode_field: 2'h0, colour_arrangement_select: 1'b0,
                       scaler_bypass_bit: 1'b0, luma_coding_select: 1'b0,
                       chroma_coding_select: 1'b0, luma_offset_level: RST_LUMA_OFFSET};
        end else if (wr_en && idx == IDX_SCALER_MODE) begin
            cfg_r.luma_offset_level <= luma_off_r;
            if (!wdata[SM_UPDATE_BIT]) begin
                cfg_r.scaling_mode_field        <= wdata[1:0];
                cfg_r.colour_arrangement_select <= wdata[3];
                cfg_r.scaler_bypass_bit         <= wdata[4];
                cfg_r.luma_coding_select        <= wdata[6];
                cfg_r.chroma_coding_select      <= wdata[7];
            end
        end
    end

    // Scaler outputs
    // Both come straight from flip-flops
    assign SCALER_CFG    = cfg_r;
    assign SCALER_UPDATE = upd_pulse_r;

endmodule : video_lock_status_scaler_regs
`default_nettype wire

// ===== tb/video_lock_status_scaler_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module video_regs_sva
    import video_regs_pkg::*;
(
    input wire logic         CLOCK,         // Clock
    input wire logic         RST_N,         // Reset, active low
    input wire logic         PSEL,          // APB select
    input wire logic         PENABLE,       // APB access
    input wire logic         PWRITE,        // APB write
    input wire logic [11:0]  PADDR,         // APB address
    input wire logic [31:0]  PWDATA,        // APB write data
    input wire logic [31:0]  PRDATA,        // APB read data
    input wire core_status_t CORE_STATUS,   // Core status
    input wire logic         XTAL_LOCKED,   // Oscillator lock
    input wire logic         XTAL_LOCK_EN,  // Locking runs
    input wire logic         VERT_FORCE,    // Vertical force
    input wire logic         FLYWHEEL_DIS,  // Flywheel off
    input wire logic         VERT_FREE_RUN, // Free run
    input wire scaler_cfg_t  SCALER_CFG,    // Scaler setting
    input wire logic         SCALER_UPDATE  // Update pulse
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Decoded access phases
    wire logic wr   = PSEL && PENABLE && PWRITE;
    wire logic rd   = PSEL && PENABLE && !PWRITE;
    wire logic w_xl = wr && PADDR == {2'h0, IDX_XLOCK_CTRL, 2'h0};
    wire logic upd  = wr && PADDR == {2'h0, IDX_SCALER_MODE, 2'h0} && !PWDATA[SM_UPDATE_BIT];
    wire logic w_yo = wr && PADDR == {2'h0, IDX_LUMA_OFFSET, 2'h0};
    logic       cmd_r; // Lock command on
    logic       thr_r; // Threshold nonzero
    logic [1:0] gv_r;  // Force and flywheel bits
    // Shadow of written control state
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_r <= 1'b0;
            thr_r <= 1'b1;
            gv_r  <= 2'h0;
        end else if (wr) begin
            if (w_xl && PWDATA[11:0] == XLOCK_CMD_ON) cmd_r <= 1'b1;
            if (w_xl && PWDATA[11:0] == XLOCK_CMD_OFF) cmd_r <= 1'b0;
            if (PADDR == {2'h0, IDX_AUTO_LOCK, 2'h0}) thr_r <= PWDATA[11:0] != 12'h0;
            if (PADDR == {2'h0, IDX_GEN_VCTRL, 2'h0}) gv_r <= {PWDATA[3], PWDATA[9]};
        end
    end
    property p_lock_on; w_xl && PWDATA[11:0] == XLOCK_CMD_ON |-> ##[1:2] XTAL_LOCK_EN; endproperty
    a_lock_on: assert property (p_lock_on) else $error("lock run missing");
    property p_lock_rd; rd && PADDR == {2'h0, IDX_XLOCK_CTRL, 2'h0} |->
        PRDATA == ($past(XTAL_LOCKED) ? {20'h0, XLOCK_RD_LOCKED} : 32'h0); endproperty
    a_lock_rd: assert property (p_lock_rd) else $error("lock readback wrong");
    property p_auto; (thr_r && !CORE_STATUS.no_signal) [*2] |=> XTAL_LOCK_EN; endproperty
    a_auto: assert property (p_auto) else $error("autolock did not start");
    property p_auto_off; (!thr_r && !cmd_r) [*3] |-> !XTAL_LOCK_EN; endproperty
    a_auto_off: assert property (p_auto_off) else $error("locking runs while off");
    property p_vctrl; {VERT_FORCE, FLYWHEEL_DIS} == $past(gv_r); endproperty
    a_vctrl: assert property (p_vctrl) else $error("vertical control outputs wrong");
    property p_free; VERT_FREE_RUN == ($past(gv_r[1]) && !$past(gv_r[0])); endproperty
    a_free: assert property (p_free) else $error("free run wrong");
    property p_status; rd && PADDR == {2'h0, IDX_STD_STATUS, 2'h0} |-> PRDATA[2:0] ==
        {$past(CORE_STATUS.no_signal), $past(CORE_STATUS.hlock), $past(CORE_STATUS.vlock)};
    endproperty
    a_status: assert property (p_status) else $error("lock status bits wrong");
    property p_cfg; upd |=> SCALER_CFG[12:7] == {$past(PWDATA[1:0]), $past(PWDATA[3]),
        $past(PWDATA[4]), $past(PWDATA[6]), $past(PWDATA[7])}; endproperty
    a_cfg: assert property (p_cfg) else $error("scaler fields not loaded");
    property p_upd; upd |=> SCALER_UPDATE ##1 !SCALER_UPDATE; endproperty
    a_upd: assert property (p_upd) else $error("update pulse wrong");
    property p_upd_src; SCALER_UPDATE |-> $past(upd); endproperty
    a_upd_src: assert property (p_upd_src) else $error("update pulse without command");
    property p_luma_hold; w_yo |=> $stable(SCALER_CFG); endproperty
    a_luma_hold: assert property (p_luma_hold) else $error("offset applied early");
endmodule : video_regs_sva
bind video_lock_status_scaler_regs video_regs_sva u_sva (.CLOCK(CLOCK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .CORE_STATUS(CORE_STATUS), .XTAL_LOCKED(XTAL_LOCKED),
    .XTAL_LOCK_EN(XTAL_LOCK_EN), .VERT_FORCE(VERT_FORCE), .FLYWHEEL_DIS(FLYWHEEL_DIS),
    .VERT_FREE_RUN(VERT_FREE_RUN), .SCALER_CFG(SCALER_CFG), .SCALER_UPDATE(SCALER_UPDATE));
`default_nettype wire

// ===== tb/video_lock_status_scaler_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module video_lock_status_scaler_regs_test;
    import video_regs_pkg::*;
    logic         clock, rst_n, psel, penable, pwrite, pready, pslverr, field_pulse;
    logic         xtal_locked, lock_en, vforce, fdis, vfree, akd, ikd, upd;
    logic [11:0]  paddr, w;
    logic [31:0]  pwdata, prdata;
    logic [63:0]  rnd;
    logic [12:0]  ex;
    logic [11:0]  gv [4];
    core_status_t cs, nc;
    scaler_cfg_t  cfg;
    logic [12:0]  exp_q [$]; // Expected {error, data} per read
    int           bad_count, n_tests, cyc, n_upd;

    video_lock_status_scaler_regs dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PSLVERR(pslverr), .PRDATA(prdata), .CORE_STATUS(cs), .FIELD_PULSE(field_pulse),
        .XTAL_LOCKED(xtal_locked), .XTAL_LOCK_EN(lock_en), .VERT_FORCE(vforce),
        .FLYWHEEL_DIS(fdis), .VERT_FREE_RUN(vfree), .AMPL_KILL_DIS(akd),
        .IDENT_KILL_DIS(ikd), .SCALER_CFG(cfg), .SCALER_UPDATE(upd));

    // Clock, 5 ns period
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, want);
        end
    endtask : chk

    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [11:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr_en;
        paddr  <= {2'h0, idx, 2'h0};
        pwdata <= {20'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [11:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    // Note the expected answer, then read
    task automatic rd(input logic [7:0] idx, input logic [11:0] d, input logic err);
        exp_q.push_back({err, d});
        apb(1'b0, idx, 12'h0);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge clock);
    endtask : settle

    // Read checker takes the oldest note
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            ex = exp_q.pop_front();
            chk(prdata, {20'h0, ex[11:0]}, "read data");
            chk(32'(pslverr), 32'(ex[12]), "slave error");
        end
    end

    // Scaler update pulses seen
    always @(posedge clock) begin
        if (upd === 1'b1) n_upd <= n_upd + 1;
    end

    // Hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        {rst_n, psel, penable, pwrite, field_pulse, xtal_locked} = 6'h0;
        paddr  = 12'h0;
        pwdata = 32'h0;
        cs     = '0;
        gv     = '{12'h008, 12'h208, 12'h200, 12'h000};
        void'($urandom(32'hb798));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        // Defaults, read-only and unmapped places
        rd(IDX_GEN_VCTRL, 12'h000, 1'b0);
        rd(IDX_SCALER_MODE, 12'h000, 1'b0);
        rd(IDX_LUMA_OFFSET, 12'h039, 1'b0);
        rd(IDX_AUTO_LOCK, 12'h190, 1'b0);
        rd(IDX_XLOCK_CTRL, 12'h000, 1'b0);
        rd(IDX_FIELD_CNT, 12'h000, 1'b0);
        wr(IDX_FW_VERSION, 12'hfff);
        rd(IDX_FW_VERSION, {FW_RELEASE, FW_INT_REV}, 1'b0);
        rd(IDX_HW_VERSION, {HW_ID_CODE, HW_INT_REV}, 1'b0);
        rd(8'h00, 12'h000, 1'b1);
        // Lock command with autolock off, then autolock
        wr(IDX_AUTO_LOCK, 12'h000);
        rd(IDX_AUTO_LOCK, 12'h000, 1'b0);
        settle;
        chk(32'(lock_en), 32'h0, "autolock off");
        wr(IDX_XLOCK_CTRL, 12'd100);
        settle;
        chk(32'(lock_en), 32'h1, "lock on");
        xtal_locked <= 1'b1;
        rd(IDX_XLOCK_CTRL, XLOCK_RD_LOCKED, 1'b0);
        wr(IDX_XLOCK_CTRL, 12'd55);
        settle;
        chk(32'(lock_en), 32'h1, "odd command");
        wr(IDX_XLOCK_CTRL, 12'd0);
        settle;
        chk(32'(lock_en), 32'h0, "lock off");
        wr(IDX_AUTO_LOCK, 12'h190);
        settle;
        chk(32'(lock_en), 32'h1, "autolock");
        // Vertical control combinations
        foreach (gv[i]) begin
            wr(IDX_GEN_VCTRL, gv[i]);
            rd(IDX_GEN_VCTRL, gv[i], 1'b0);
            settle;
            chk(32'({vforce, fdis, vfree}), 32'({gv[i][3], gv[i][9], gv[i][3] & ~gv[i][9]}),
                "vertical");
        end
        // Random status and measurements
        repeat (3) begin
            rnd = {$urandom(), $urandom()};
            nc  = rnd[44:0];
            w   = rnd[63:52] & 12'h050;
            cs <= nc;
            wr(IDX_STD_STATUS, w);
            rd(IDX_STD_STATUS, {2'h0, nc.spur_vsync, nc.no_vsync, nc.interlace, w[6],
                nc.ident_kill, w[4], nc.ampl_kill, nc.no_signal, nc.hlock, nc.vlock},
                1'b0);
            rd(IDX_LINES_FIELD, nc.std_50hz ? 12'd312 : 12'd262, 1'b0);
            rd(IDX_SYNC_AMPL, nc.sync_ampl, 1'b0);
            rd(IDX_BURST_AMPL, nc.burst_ampl, 1'b0);
            rd(IDX_NOISE, nc.noise, 1'b0);
            settle;
            chk(32'({akd, ikd}), 32'({w[4], w[6]}), "killer disable");
        end
        // Five fields
        repeat (5) begin
            @(posedge clock);
            field_pulse <= 1'b1;
            @(posedge clock);
            field_pulse <= 1'b0;
        end
        rd(IDX_FIELD_CNT, 12'd5, 1'b0);
        // Offset waits for the scaler mode write
        wr(IDX_LUMA_OFFSET, 12'd4);
        settle;
        chk(32'(cfg.luma_offset_level), 32'd57, "offset early");
        rd(IDX_LUMA_OFFSET, 12'd4, 1'b0);
        for (int i = 0; i < 4; i++) begin
            w = (12'($urandom()) & 12'h0d8) | {10'h0, i[0], 1'b0};
            wr(IDX_SCALER_MODE, w);
            settle;
            chk(32'(cfg), 32'({w[1:0], w[3], w[4], w[6], w[7], 7'd4}), "scaler");
            rd(IDX_SCALER_MODE, w | 12'h800, 1'b0);
        end
        wr(IDX_SCALER_MODE, 12'h800);
        settle;
        chk(32'(cfg.scaling_mode_field), 32'(w[1:0]), "no update");
        rd(IDX_SCALER_MODE, 12'h800, 1'b0);
        chk(n_upd, 32'd4, "update pulses");
        settle;
        conclude();
    end
endmodule : video_lock_status_scaler_regs_test
`default_nettype wire
